// *** core/single_row_buffer.sv ***
// Single data-row video buffer with RAM replay
module srb_single_row_buffer
  import srb_pkg::*;
#(
  parameter int DEPTH = SRB_DEPTH_BIG
)(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_char_clk,
  input  wire logic                  i_write_enable_n,
  input  wire logic                  i_counter_clear_n,
  input  wire logic                  i_count_gate,
  input  wire logic                  i_output_enable_n,
  input  wire logic [SRB_DATA_W-1:0] i_input_byte,
  output logic      [SRB_DATA_W-1:0] o_output_byte,
  output logic      [SRB_DATA_W-1:0] o_output_byte_oe,
  output logic                       o_overflow_flag
);
  localparam logic [SRB_ADDR_W-1:0] MAX_ADDR = SRB_ADDR_W'(DEPTH - 1);

  // Pin synchronisers: stage one is read only by stage two
  srb_ctrl_t                 sync1_reg, sync1_next;
  srb_ctrl_t                 sync2_reg, sync2_next;
  srb_ctrl_t                 prev_reg,  prev_next;
  logic [SRB_DATA_W-1:0]     din1_reg,  din1_next;
  logic [SRB_DATA_W-1:0]     din2_reg,  din2_next;
  logic                      oen1_reg,  oen1_next;
  logic                      oen2_reg,  oen2_next;

  logic [SRB_DATA_W-1:0]     mem [DEPTH];
  logic [SRB_DATA_W-1:0]     in_latch_reg,  in_latch_next;
  logic [SRB_DATA_W-1:0]     out_latch_reg, out_latch_next;
  logic [SRB_ADDR_W-1:0]     addr_reg,      addr_next;
  logic                      loading_reg,   loading_next;
  logic                      full_reg,      full_next;
  logic                      clr_pend_reg,  clr_pend_next;
  logic [SRB_DATA_W-1:0]     oe_reg,        oe_next;
  logic                      ovf_reg,       ovf_next;

  logic                      fall;
  logic                      clr_fall;
  logic                      wr_now;

  // High-to-low step between the previous and the current synchronised sample
  function automatic logic falling(input logic was_v, input logic now_v);
    falling = was_v & ~now_v;
  endfunction : falling

  always_comb
  begin
    sync1_next = '{count_gate: i_count_gate, write_enable_n: i_write_enable_n,
                   counter_clear_n: i_counter_clear_n, char_clk: i_char_clk};
    sync2_next = sync1_reg;
    prev_next  = sync2_reg;
    din1_next  = i_input_byte;
    din2_next  = din1_reg;
    oen1_next  = i_output_enable_n;
    oen2_next  = oen1_reg;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      sync1_reg <= SRB_CTRL_RST;
      sync2_reg <= SRB_CTRL_RST;
      prev_reg  <= SRB_CTRL_RST;
      din1_reg  <= SRB_BYTE_RST;
      din2_reg  <= SRB_BYTE_RST;
      oen1_reg  <= 1'b1;
      oen2_reg  <= 1'b1;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
      din1_reg  <= din1_next;
      din2_reg  <= din2_next;
      oen1_reg  <= oen1_next;
      oen2_reg  <= oen2_next;
    end
  end

  // Falling edge of the character clock is the one-cycle working enable
  assign fall     = falling(prev_reg.char_clk, sync2_reg.char_clk);
  assign clr_fall = falling(prev_reg.counter_clear_n, sync2_reg.counter_clear_n);

  // Write happens with the byte latched on the previous falling edge
  assign wr_now = fall & loading_reg & ~full_reg & ~sync2_reg.write_enable_n;

  always_comb
  begin
    in_latch_next  = in_latch_reg;
    out_latch_next = out_latch_reg;
    addr_next      = addr_reg;
    loading_next   = loading_reg;
    full_next      = full_reg;
    clr_pend_next  = clr_pend_reg | clr_fall;
    ovf_next       = (addr_reg == MAX_ADDR);
    oe_next        = {SRB_DATA_W{~oen2_reg}};
    if (fall)
    begin
      in_latch_next = din2_reg;
      if (!sync2_reg.write_enable_n)
        out_latch_next = in_latch_reg;
      else
        out_latch_next = mem[addr_reg];
      // Loading covers the gated clocks after the first, plus the one after the gate drops
      loading_next = sync2_reg.count_gate;
      if (clr_pend_reg | clr_fall)
      begin
        addr_next     = SRB_ADDR_RST;
        full_next     = 1'b0;
        clr_pend_next = 1'b0;
      end
      else if (sync2_reg.count_gate & loading_reg)
      begin
        if (addr_reg == MAX_ADDR)
          full_next = 1'b1;
        else
          addr_next = addr_reg + SRB_ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (wr_now)
      mem[addr_reg] <= in_latch_reg;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      in_latch_reg  <= SRB_BYTE_RST;
      out_latch_reg <= SRB_BYTE_RST;
      addr_reg      <= SRB_ADDR_RST;
      loading_reg   <= 1'b0;
      full_reg      <= 1'b0;
      clr_pend_reg  <= 1'b0;
      oe_reg        <= '0;
      ovf_reg       <= 1'b0;
    end
    else
    begin
      in_latch_reg  <= in_latch_next;
      out_latch_reg <= out_latch_next;
      addr_reg      <= addr_next;
      loading_reg   <= loading_next;
      full_reg      <= full_next;
      clr_pend_reg  <= clr_pend_next;
      oe_reg        <= oe_next;
      ovf_reg       <= ovf_next;
    end
  end

  assign o_output_byte    = out_latch_reg;
  assign o_output_byte_oe = oe_reg;
  assign o_overflow_flag  = ovf_reg;
endmodule : srb_single_row_buffer

// *** core/srb_pkg.sv ***
// Package with constants and types for the single row buffer
// Behaviour
// - Latches and counter update on the falling edge of the character clock.
// - Input byte is latched on every character clock, regardless of enables.
// - Address counter advances only while count gate is high.
// - Write enable low forwards input latch to output and stores it in RAM.
// - RAM is written only while loading (gate high on the previous clock) and write enable low.
// - Falling edge on counter clear resets the address counter to zero.
// - First gated clock only latches; the next stores at location zero, then increment, latch, store.
// - Loading stops one clock after gate drops or when buffer is full.
// - While writing, output shows each byte as it is stored, one clock after it is latched.
// - With write enable high, stored bytes are replayed from RAM in order.
// - Overflow flag goes high when the counter reaches its maximum count.
// - Output enable low drives the data outputs, high releases them.
// - Bytes are eight bits wide; row length set by the gate duration.
// - Capacity is 135 bytes, or 83 for the smaller variant.
package srb_pkg;
  localparam int          SRB_DATA_W    = 8;
  localparam int          SRB_DEPTH_BIG = 135;
  localparam int          SRB_DEPTH_SML = 83;
  localparam int          SRB_ADDR_W    = 8;
  localparam logic [7:0]  SRB_BYTE_RST  = 8'h00;
  localparam logic [7:0]  SRB_ADDR_RST  = 8'h00;

  typedef struct packed {
    logic       count_gate;
    logic       write_enable_n;
    logic       counter_clear_n;
    logic       char_clk;
  } srb_ctrl_t;

  // Pin idle levels; character clock starts low so no false falling edge follows reset
  localparam srb_ctrl_t   SRB_CTRL_RST  = '{count_gate: 1'b0, write_enable_n: 1'b1,
                                            counter_clear_n: 1'b1, char_clk: 1'b0};
endpackage : srb_pkg

// *** tb/srb_buffer_checker.sv ***
// Port checker for the single row buffer
module srb_buffer_checker
  import srb_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_char_clk,
  input wire logic       i_write_enable_n,
  input wire logic       i_counter_clear_n,
  input wire logic       i_count_gate,
  input wire logic       i_output_enable_n,
  input wire logic [7:0] i_input_byte,
  input wire logic [7:0] o_output_byte,
  input wire logic [7:0] o_output_byte_oe,
  input wire logic       o_overflow_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic [7:0] last_reg;
  sequence s_fall;
    $fell(i_char_clk);
  endsequence
  // Byte seen at the previous character clock fall
  always_ff @(posedge i_core_clk)
    if (!i_reset_n)
      last_reg <= 8'h00;
    else if ($fell(i_char_clk))
      last_reg <= i_input_byte;
  property p_pass;
    logic [7:0] v;
    (!i_write_enable_n ##0 s_fall, v = last_reg) |-> ##6 o_output_byte == v;
  endproperty
  AST_PASS: assert property (p_pass) else $error("pass byte");
  AST_OE_ON: assert property (!i_output_enable_n [*5] |-> o_output_byte_oe == 8'hff) else $error("oe on");
  AST_OE_OFF: assert property (i_output_enable_n [*5] |-> o_output_byte_oe == 8'h00) else $error("oe off");
  AST_OUT_HOLD: assert property (i_char_clk [*8] |-> $stable(o_output_byte)) else $error("out moved");
  AST_OVF_HOLD: assert property (i_char_clk [*8] |-> $stable(o_overflow_flag)) else $error("flag moved");
  AST_CLR: assert property ($fell(i_counter_clear_n) ##[4:7] s_fall |-> ##7 !o_overflow_flag) else $error("clr");
  AST_OVF_GATE: assert property ($rose(o_overflow_flag) |-> $past(i_count_gate, 6)) else $error("gate");
  AST_OVF_KEEP: assert property ($fell(o_overflow_flag) |-> !$past(i_counter_clear_n, 7)) else $error("kept");
endmodule : srb_buffer_checker
bind srb_single_row_buffer srb_buffer_checker u_chk (.*);

// *** tb/srb_char_clk_model.sv ***
// Character clock source of the display controller
module srb_char_clk_model
(
  input  wire logic i_core_clk,
  output logic      o_char_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg = 4'h0;
  always_ff @(posedge i_core_clk)
    cnt_reg <= cnt_reg + 4'h1;
  assign o_char_clk = cnt_reg[3];
endmodule : srb_char_clk_model

// *** tb/srb_single_row_buffer_tb_top.sv ***
// Bench for the single row buffer
module srb_single_row_buffer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, ck, g = 0, w = 1, c = 1, oe_n = 0, pc = 1, ld = 0, full = 0, ovf;
  localparam int AMAX = srb_pkg::SRB_DEPTH_BIG - 1;
  logic [7:0] d = 8'h00, lat = 8'h00, e, q, qe, q2;
  logic [7:0] m [0:255];
  logic [31:0] s = 32'h28f4;
  int a = 0, miscompares = 0, comparisons = 0, cyc = 0;
  always #50 clk = ~clk;
  srb_char_clk_model u_ccm (.i_core_clk(clk), .o_char_clk(ck));
  srb_single_row_buffer u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_char_clk(ck), .i_write_enable_n(w),
    .i_counter_clear_n(c), .i_count_gate(g), .i_output_enable_n(oe_n), .i_input_byte(d),
    .o_output_byte(q), .o_output_byte_oe(qe), .o_overflow_flag(ovf));
  // Second buffer cascaded behind the first through its overflow flag
  srb_single_row_buffer u_casc (.i_core_clk(clk), .i_reset_n(rst_n), .i_char_clk(ck), .i_write_enable_n(w),
    .i_counter_clear_n(c), .i_count_gate(ovf), .i_output_enable_n(oe_n), .i_input_byte(d),
    .o_output_byte(q2), .o_output_byte_oe(), .o_overflow_flag());
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // One character clock: drive, update model, compare after the fall
  task automatic step(input logic gi, input logic wi, input logic ci);
    @(posedge ck);
    @(posedge clk);
    #1;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    {g, w, c, d, oe_n} = {gi, wi, ci, s[7:0], s[8]};
    // Store at the current address, then clear or advance it
    e = w ? m[a] : lat;
    if (!w && ld && !full)
      m[a] = lat;
    if (!c && pc)
    begin
      a = 0;
      full = 0;
    end
    else if (g && ld)
    begin
      if (a == AMAX)
        full = 1;
      else
        a++;
    end
    ld = g;
    lat = d;
    pc = c;
    @(negedge ck);
    repeat (7) @(posedge clk);
    #1;
    if (c)
      chk(q === e, "output byte");
    chk(ovf === (a == AMAX), "overflow flag");
    if (!w)
      chk(q2 === e, "cascade output byte");
    chk(qe === {8{~oe_n}}, "output enable");
  endtask : step
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    for (int r = 0; r < 2; r++)
      for (int l = 0; l < 3; l++)
      begin
        step(0, l > 0, 0);
        repeat (r ? 140 : 10) step(1, l > 0, 1);
        repeat (2) step(0, l > 0, 1);
        $display("row %0d line %0d done", r, l);
      end
    summarize();
  end
endmodule : srb_single_row_buffer_tb_top
